// ---- src/rst_seq_pkg.sv ----
// Constants, register map and states of the reset sequencer.
// Shared by the sequencer module and by anything that decodes its registers.
package rst_seq_pkg;
    // Register byte addresses on the classic Wishbone slave
    localparam logic [7:0] ADR_CAUSE = 8'h00;
    localparam logic [7:0] ADR_IRQ_STAT = 8'h04;
    localparam logic [7:0] ADR_IRQ_EN = 8'h08;
    localparam logic [7:0] ADR_IRQ_CLR = 8'h0c;

    // Bit positions in the reset cause register; bit 0 is reserved, reads 0
    localparam int F_LOWV = 1;
    localparam int F_MON = 2;
    localparam int F_BADADR = 3;
    localparam int F_BADOP = 4;
    localparam int F_WDOG = 5;
    localparam int F_PIN = 6;
    localparam int F_POR = 7;
    localparam logic [7:0] CAUSE_POR_RST = 8'h80;

    // Interrupt status bits
    localparam int IRQ_W = 3;
    localparam int I_DONE = 0;
    localparam int I_LATE = 1;
    localparam int I_LOWV = 2;
    localparam logic [2:0] IRQ_RST = 3'h0;

    // Sequence timing in reference clock cycles; clock period in ps, minimum low time in ns
    localparam int CNT_W = 13;
    localparam int STAB_CYC = 4096;
    localparam int PIN_DRIVE_CYC = 32;
    localparam int HOLD_CYC = 32;
    localparam int CLK_PERIOD_PS = 8000;
    localparam int MIN_LOW_NS = 100;
    localparam int MIN_LOW_CYC = (MIN_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WDOG_W = 20;
    localparam int BUS_DIV = 4;

    localparam logic [15:0] VECTOR_ADDR = 16'hfffe;

    typedef enum logic [2:0] {S_IDLE, S_STAB, S_LOWV, S_DRIVE, S_HOLD, S_EXT} seq_state_e;
endpackage

// ---- src/reset_sequencer.sv ----
// Reset sequencer with reset cause log, watchdog and interrupt status.
// Assumes a single 125 MHz reference clock, a CPU on the same clock for
// the event inputs, and an external pull-up on the open-drain reset pin.
//
// Functional notes
// - Any reset aborts the CPU at once; restart loads the vector at the top address.
// - Leaving reset, the bus clock is the reference clock divided by four.
// - Outside party holding pin low for minimum time causes external reset, flag set.
// - Every internal source drives the reset pin low for 32 cycles.
// - After pin release following internal reset, hold in reset 32 more cycles.
// - Power-on: clocks gated and pin driven low for 4096 stabilization cycles.
// - Power-on and low-voltage: pin released at 32, CPU fetch at 64 after delay.
// - Power-on sets its own flag and clears every other flag.
// - Watchdog overflow resets and sets its flag; writing the watchdog location prevents it.
// - Low supply drives pin low; after recovery, 4096 gated cycles, then flag set.
// - Bad opcode, or stop while stop is disabled, resets and sets bad-opcode flag.
// - Opcode fetch from unmapped address resets and sets flag; data fetch does not.
// - Cause register is read-only; a read clears all flags, nothing but power-on else does.
// - Flags from several resets stay set together until read.
// - Pin sampled 32 cycles after release; still low also sets external flag.
// - Forced monitor mode entry resets and sets the monitor-entry flag.
//
// The Wishbone register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module reset_sequencer #(
    parameter int WDOG_CYCLES = 262144
) (
    input wire logic REF_CLK, // Reference clock
    input wire logic RESETN, // Power-on reset, synchronous, active low
    input wire logic RST_PIN_I, // Reset pin level, asynchronous
    output logic RST_PIN_O, // Reset pin drive value, always low
    output logic RST_PIN_OE_N, // Low while the pin is driven low
    input wire logic LOW_SUPPLY, // Supply below rising trip level, asynchronous
    input wire logic BAD_OPCODE, // Pulse, opcode outside the set
    input wire logic STOP_EXEC, // Pulse, stop instruction executed
    input wire logic STOP_ENABLE, // Stop-enable bit of system_config_one
    input wire logic FETCH_UNMAPPED, // Pulse, fetch from unmapped address
    input wire logic FETCH_IS_OPCODE, // Qualifies FETCH_UNMAPPED as opcode fetch
    input wire logic MONITOR_ENTRY, // Pulse, forced monitor mode entry
    input wire logic WDOG_KICK, // Pulse, write to the watchdog location
    output logic CPU_RESET, // CPU held in reset, aborts at once
    output logic CLOCKS_GATED, // CPU and module clocks held inactive
    output logic VECTOR_FETCH, // Pulse, start of the vector fetch
    output logic [15:0] VECTOR_ADDR, // Address of the reset vector
    output logic BUS_CLK, // Bus clock, reference divided by four
    output logic IRQ, // Level interrupt
    input wire logic WB_CYC_I, // Wishbone cycle
    input wire logic WB_STB_I, // Wishbone strobe
    input wire logic WB_WE_I, // Wishbone write enable
    input wire logic [7:0] WB_ADR_I, // Wishbone byte address
    input wire logic [3:0] WB_SEL_I, // Wishbone byte selects
    input wire logic [31:0] WB_DAT_I, // Wishbone write data
    output logic [31:0] WB_DAT_O, // Wishbone read data
    output logic WB_ACK_O // Wishbone acknowledge
);
    rst_seq_pkg::seq_state_e st_r, st_nxt;
    logic [rst_seq_pkg::CNT_W-1:0] cnt_r;
    logic pin_m_r, pin_s_r, sup_m_r, sup_s_r;
    logic [rst_seq_pkg::CNT_W-1:0] low_cnt_r;
    logic [rst_seq_pkg::WDOG_W-1:0] wd_cnt_r;
    logic lowsup_mode_r, oe_n_r, gated_r, vec_r;
    logic [1:0] bdiv_r;
    logic [7:0] cause_r, set_vec;
    logic [rst_seq_pkg::IRQ_W-1:0] ist_r, ien_r, iset;
    logic ack_r;
    logic [31:0] dat_r;
    logic req, rd_cause, wd_trig, ext_trig, int_trig, cnt_end, sample_now, stab_done;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);

    // Two-stage synchronisers for the pin and the supply detector
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            pin_m_r <= 1'b1;
            pin_s_r <= 1'b1;
            sup_m_r <= 1'b0;
            sup_s_r <= 1'b0;
        end else begin
            pin_m_r <= RST_PIN_I;
            pin_s_r <= pin_m_r;
            sup_m_r <= LOW_SUPPLY;
            sup_s_r <= sup_m_r;
        end
    end

    // Outside low pulse must last the minimum low time
    always_ff @(posedge REF_CLK) begin
        if (!RESETN || pin_s_r || st_r != rst_seq_pkg::S_IDLE) begin
            low_cnt_r <= '0;
        end else if (!ext_trig) begin
            low_cnt_r <= low_cnt_r + 1'b1;
        end
    end
    assign ext_trig = low_cnt_r == rst_seq_pkg::CNT_W'(rst_seq_pkg::MIN_LOW_CYC - 1);

    // Watchdog counter, cleared by software writes to its location
    always_ff @(posedge REF_CLK) begin
        if (!RESETN || WDOG_KICK || st_r != rst_seq_pkg::S_IDLE) begin
            wd_cnt_r <= '0;
        end else begin
            wd_cnt_r <= wd_cnt_r + 1'b1;
        end
    end
    assign wd_trig = wd_cnt_r == rst_seq_pkg::WDOG_W'(WDOG_CYCLES - 1);

    // Internal sources, accepted only while running; low-voltage and late-pin flags set during the sequence
    always_comb begin
        set_vec = 8'h00;
        if (st_r == rst_seq_pkg::S_IDLE) begin
            set_vec[rst_seq_pkg::F_WDOG] = wd_trig;
            set_vec[rst_seq_pkg::F_BADOP] = BAD_OPCODE | (STOP_EXEC & ~STOP_ENABLE);
            set_vec[rst_seq_pkg::F_BADADR] = FETCH_UNMAPPED & FETCH_IS_OPCODE;
            set_vec[rst_seq_pkg::F_MON] = MONITOR_ENTRY;
            set_vec[rst_seq_pkg::F_PIN] = ext_trig;
        end
        set_vec[rst_seq_pkg::F_LOWV] = stab_done & lowsup_mode_r;
        set_vec[rst_seq_pkg::F_PIN] = set_vec[rst_seq_pkg::F_PIN] | (sample_now & ~pin_s_r);
    end
    assign int_trig = |set_vec[rst_seq_pkg::F_WDOG:rst_seq_pkg::F_MON];

    assign cnt_end = (st_r == rst_seq_pkg::S_STAB) ?
        (cnt_r == rst_seq_pkg::CNT_W'(rst_seq_pkg::STAB_CYC - 1)) :
        (st_r == rst_seq_pkg::S_DRIVE) ?
        (cnt_r == rst_seq_pkg::CNT_W'(rst_seq_pkg::PIN_DRIVE_CYC - 1)) :
        (cnt_r == rst_seq_pkg::CNT_W'(rst_seq_pkg::HOLD_CYC - 1));
    assign stab_done = st_r == rst_seq_pkg::S_STAB && cnt_end && !sup_s_r;
    assign sample_now = st_r == rst_seq_pkg::S_HOLD && cnt_end;

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            rst_seq_pkg::S_IDLE: begin
                if (sup_s_r) begin
                    st_nxt = rst_seq_pkg::S_LOWV;
                end else if (int_trig) begin
                    st_nxt = rst_seq_pkg::S_DRIVE;
                end else if (ext_trig) begin
                    st_nxt = rst_seq_pkg::S_EXT;
                end
            end
            rst_seq_pkg::S_LOWV: begin
                if (!sup_s_r) begin
                    st_nxt = rst_seq_pkg::S_STAB;
                end
            end
            rst_seq_pkg::S_STAB: begin
                if (sup_s_r) begin
                    st_nxt = rst_seq_pkg::S_LOWV;
                end else if (cnt_end) begin
                    st_nxt = rst_seq_pkg::S_DRIVE;
                end
            end
            rst_seq_pkg::S_DRIVE: begin
                if (sup_s_r) begin
                    st_nxt = rst_seq_pkg::S_LOWV;
                end else if (cnt_end) begin
                    st_nxt = rst_seq_pkg::S_HOLD;
                end
            end
            rst_seq_pkg::S_HOLD: begin
                if (sup_s_r) begin
                    st_nxt = rst_seq_pkg::S_LOWV;
                end else if (cnt_end) begin
                    st_nxt = rst_seq_pkg::S_IDLE;
                end
            end
            rst_seq_pkg::S_EXT: begin
                if (sup_s_r) begin
                    st_nxt = rst_seq_pkg::S_LOWV;
                end else if (pin_s_r) begin
                    st_nxt = rst_seq_pkg::S_HOLD;
                end
            end
            default: st_nxt = rst_seq_pkg::S_IDLE;
        endcase
    end

    // Power-on starts in the stabilization delay
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            st_r <= rst_seq_pkg::S_STAB;
            cnt_r <= '0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= (st_nxt != st_r) ? '0 : cnt_r + 1'b1;
        end
    end

    // Remembers that the delay follows a low-supply episode
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            lowsup_mode_r <= 1'b0;
        end else if (st_r == rst_seq_pkg::S_LOWV) begin
            lowsup_mode_r <= 1'b1;
        end else if (st_r == rst_seq_pkg::S_DRIVE) begin
            lowsup_mode_r <= 1'b0;
        end
    end

    // Pin and clock gate registered from the next state, vector pulse from the hold end
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            oe_n_r <= 1'b0;
            gated_r <= 1'b1;
            vec_r <= 1'b0;
        end else begin
            oe_n_r <= !(st_nxt == rst_seq_pkg::S_LOWV || st_nxt == rst_seq_pkg::S_STAB ||
                        st_nxt == rst_seq_pkg::S_DRIVE);
            gated_r <= st_nxt == rst_seq_pkg::S_LOWV || st_nxt == rst_seq_pkg::S_STAB;
            vec_r <= sample_now && !sup_s_r;
        end
    end
    assign RST_PIN_O = 1'b0;
    assign RST_PIN_OE_N = oe_n_r;
    assign CLOCKS_GATED = gated_r;
    assign VECTOR_FETCH = vec_r;
    assign VECTOR_ADDR = rst_seq_pkg::VECTOR_ADDR;
    assign CPU_RESET = st_r != rst_seq_pkg::S_IDLE || int_trig || sup_s_r || ext_trig;

    // Bus clock divider, restarted by every reset
    always_ff @(posedge REF_CLK) begin
        if (!RESETN || CPU_RESET) begin
            bdiv_r <= 2'h0;
        end else begin
            bdiv_r <= bdiv_r + 2'((rst_seq_pkg::BUS_DIV) / 4);
        end
    end
    assign BUS_CLK = bdiv_r[1];

    // Wishbone slave, one wait-free answer a cycle after the request
    assign req = WB_CYC_I && WB_STB_I && !ack_r;
    assign rd_cause = req && !WB_WE_I && WB_ADR_I == rst_seq_pkg::ADR_CAUSE;

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0;
        end else begin
            ack_r <= req;
            if (req && !WB_WE_I) begin
                case (WB_ADR_I)
                    rst_seq_pkg::ADR_CAUSE: dat_r <= {24'h0, cause_r};
                    rst_seq_pkg::ADR_IRQ_STAT: dat_r <= {29'h0, ist_r};
                    rst_seq_pkg::ADR_IRQ_EN: dat_r <= {29'h0, ien_r};
                    default: dat_r <= 32'h0;
                endcase
            end
        end
    end
    assign WB_ACK_O = ack_r;
    assign WB_DAT_O = dat_r;

    // Cause log: power-on leaves only its own flag, a read clears, sets win
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            cause_r <= rst_seq_pkg::CAUSE_POR_RST;
        end else begin
            cause_r <= (rd_cause ? 8'h00 : cause_r) | set_vec;
        end
    end

    // Interrupt status, enable and write-one-to-clear
    assign iset = {sup_s_r & ~lowsup_mode_r, sample_now & ~pin_s_r, vec_r};
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            ist_r <= rst_seq_pkg::IRQ_RST;
            ien_r <= rst_seq_pkg::IRQ_RST;
        end else begin
            if (req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == rst_seq_pkg::ADR_IRQ_CLR) begin
                ist_r <= (ist_r & ~WB_DAT_I[rst_seq_pkg::IRQ_W-1:0]) | iset;
            end else begin
                ist_r <= ist_r | iset;
            end
            if (req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == rst_seq_pkg::ADR_IRQ_EN) begin
                ien_r <= WB_DAT_I[rst_seq_pkg::IRQ_W-1:0];
            end
        end
    end
    assign IRQ = |(ist_r & ien_r);

    a_abort_now: assert property (int_trig |->
        CPU_RESET ##1 (CPU_RESET && !RST_PIN_OE_N))
        else $error("internal reset did not abort the CPU");
    a_bus_div: assert property (disable iff (!RESETN || CPU_RESET)
        $rose(BUS_CLK) |-> BUS_CLK ##1 BUS_CLK ##1 !BUS_CLK ##1 !BUS_CLK)
        else $error("bus clock is not the reference divided by four");
    a_drive_len: assert property ($rose(st_r == rst_seq_pkg::S_DRIVE) |->
        ##31 st_r == rst_seq_pkg::S_DRIVE ##1 st_r != rst_seq_pkg::S_DRIVE)
        else $error("pin drive phase is not 32 cycles");
    a_drive_low: assert property (st_r == rst_seq_pkg::S_DRIVE |-> !RST_PIN_OE_N)
        else $error("reset pin not driven in drive phase");
    a_hold_len: assert property ($rose(st_r == rst_seq_pkg::S_HOLD) && !sup_s_r |->
        ##31 CPU_RESET ##1 VECTOR_FETCH)
        else $error("hold after release is not 32 cycles");
    a_stab_gate: assert property (st_r == rst_seq_pkg::S_STAB |->
        CLOCKS_GATED && !RST_PIN_OE_N)
        else $error("clocks or pin wrong during stabilization");
    a_vec_after: assert property ($fell(st_r == rst_seq_pkg::S_STAB) && !sup_s_r |->
        ##32 RST_PIN_OE_N ##32 VECTOR_FETCH)
        else $error("release or fetch late after stabilization");
    a_read_clear: assert property (rd_cause && set_vec == 8'h00 |=> cause_r == 8'h00)
        else $error("read did not clear the cause flags");
    a_flags_keep: assert property (!rd_cause |=>
        (cause_r & $past(cause_r)) == $past(cause_r))
        else $error("cause flag lost without a read");
    a_pin_sample: assert property (sample_now && !pin_s_r |=> cause_r[rst_seq_pkg::F_PIN])
        else $error("late low pin did not set the external flag");

    a_hold_pin: assert property (st_r == rst_seq_pkg::S_HOLD |->
        RST_PIN_OE_N && CPU_RESET)
        else $error("pin driven or CPU running during hold");

    a_run_ungated: assert property (!CPU_RESET |-> !CLOCKS_GATED)
        else $error("clocks gated while the CPU runs");

    a_cpu_release: assert property ($fell(CPU_RESET) |-> VECTOR_FETCH)
        else $error("CPU released without a vector fetch");

    a_ext_flag: assert property (ext_trig |=> cause_r[rst_seq_pkg::F_PIN])
        else $error("external reset did not set its flag");

    a_wdog_flag: assert property (wd_trig && st_r == rst_seq_pkg::S_IDLE |->
        CPU_RESET ##1 cause_r[rst_seq_pkg::F_WDOG])
        else $error("watchdog overflow did not reset with its flag");

    a_kick_clear: assert property (WDOG_KICK |=> wd_cnt_r == '0)
        else $error("watchdog counter not cleared by a kick");

    a_lowv_pull: assert property (sup_s_r |=> !RST_PIN_OE_N && CLOCKS_GATED)
        else $error("low supply did not drive the pin and gate clocks");

    a_lowv_flag: assert property (stab_done && lowsup_mode_r |=>
        cause_r[rst_seq_pkg::F_LOWV])
        else $error("low-voltage flag not set after the delay");

    a_badop_flag: assert property (st_r == rst_seq_pkg::S_IDLE &&
        (BAD_OPCODE || (STOP_EXEC && !STOP_ENABLE)) |=> cause_r[rst_seq_pkg::F_BADOP])
        else $error("bad opcode did not set its flag");

    a_fetch_flag: assert property (st_r == rst_seq_pkg::S_IDLE &&
        FETCH_UNMAPPED && FETCH_IS_OPCODE |=> cause_r[rst_seq_pkg::F_BADADR])
        else $error("opcode fetch from unmapped address did not set its flag");

    a_data_fetch: assert property (st_r == rst_seq_pkg::S_IDLE &&
        FETCH_UNMAPPED && !FETCH_IS_OPCODE && !BAD_OPCODE && !STOP_EXEC &&
        !MONITOR_ENTRY && !wd_trig && !ext_trig && !sup_s_r |-> !CPU_RESET)
        else $error("data fetch from unmapped address caused a reset");

    a_mon_flag: assert property (st_r == rst_seq_pkg::S_IDLE && MONITOR_ENTRY |=>
        cause_r[rst_seq_pkg::F_MON])
        else $error("monitor entry did not set its flag");
endmodule

// ---- test/reset_pin_partner.sv ----
// Model of the outside reset circuitry sharing the open-drain reset line.
// Assumes a pull-up on the line; the bench asks for low holds of a given length.
`timescale 1ns/1ps
module reset_pin_partner (
    input wire logic clk, // Reference clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic oe_n, // Device pull-down enable, active low
    input wire logic go, // Load a new hold length
    input wire logic [15:0] hold_len, // Cycles to hold the line low
    output logic pin // Resolved line level
);
    logic [15:0] left_r;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            left_r <= 16'h0;
        end else if (go) begin
            left_r <= hold_len;
        end else if (left_r != 16'h0) begin
            left_r <= left_r - 16'h1;
        end
    end
    // Pull-up wins only when neither party pulls the line low
    assign pin = (oe_n == 1'b0 || left_r != 16'h0) ? 1'b0 : 1'b1;
endmodule

// ---- test/tb_reset_sequencer.sv ----
// Self-checking bench for the reset sequencer: Wishbone register access,
// event triggers, supply and reset-line stimulus. Assumes the line partner model.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, s); end end
module tb_reset_sequencer;
    logic clk, resetn, low_supply, stop_enable, fetch_is_opcode, wdog_kick, kick_en;
    logic wb_cyc, wb_stb, wb_we, wb_ack, rst_pin, oe_n, cpu_reset, gated, vf, bus_clk, irq;
    logic ext_go, prev, pin_o;
    logic [3:0] trig, wb_sel;
    logic [7:0] wb_adr;
    logic [15:0] vec_addr, hold_len;
    logic [31:0] wb_dat_w, wb_dat_r, d;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n, lo, g, r, hi, tr;

    reset_sequencer #(.WDOG_CYCLES(64)) dut (.REF_CLK(clk), .RESETN(resetn),
        .RST_PIN_I(rst_pin), .RST_PIN_O(pin_o), .RST_PIN_OE_N(oe_n), .LOW_SUPPLY(low_supply),
        .BAD_OPCODE(trig[0]), .STOP_EXEC(trig[1]), .STOP_ENABLE(stop_enable),
        .FETCH_UNMAPPED(trig[2]), .FETCH_IS_OPCODE(fetch_is_opcode),
        .MONITOR_ENTRY(trig[3]), .WDOG_KICK(wdog_kick), .CPU_RESET(cpu_reset),
        .CLOCKS_GATED(gated), .VECTOR_FETCH(vf), .VECTOR_ADDR(vec_addr), .BUS_CLK(bus_clk),
        .IRQ(irq), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb), .WB_WE_I(wb_we), .WB_ADR_I(wb_adr),
        .WB_SEL_I(wb_sel), .WB_DAT_I(wb_dat_w), .WB_DAT_O(wb_dat_r), .WB_ACK_O(wb_ack));
    reset_pin_partner line (.clk(clk), .rst_n(resetn), .oe_n(oe_n), .go(ext_go),
        .hold_len(hold_len), .pin(rst_pin));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task conclude;
        $display("mismatches %0d comparisons %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Periodic watchdog service; also the run-time ceiling
    always @(posedge clk) begin
        cycles <= cycles + 1;
        wdog_kick <= kick_en && (cycles % 32 == 0);
        if (cycles >= 20000) begin
            num_errors++;
            conclude();
        end
    end

    task wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] wd);
        int t;
        t = 0;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= 4'hf;
        wb_dat_w <= wd;
        // Ack and read data are taken at the rising edge that samples ack high
        do begin
            @(posedge clk);
            t++;
        end while (wb_ack !== 1'b1 && t < 50);
        `CHK("ack", 1'b1, wb_ack)
        d = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_sel <= 4'h0;
    endtask

    // Counts cycles until the vector fetch, with pin-low and gated cycles
    task wait_vf;
        n = 0;
        lo = (oe_n === 1'b0);
        g = (gated === 1'b1);
        do begin
            @(posedge clk);
            trig <= 4'h0;
            ext_go <= 1'b0;
            #1;
            n++;
            lo += (oe_n === 1'b0);
            g += (gated === 1'b1);
        end while (vf !== 1'b1 && n < 6000);
    endtask

    task idle_chk(input int m);
        r = 0;
        repeat (m) begin
            @(posedge clk);
            trig <= 4'h0;
            ext_go <= 1'b0;
            #1;
            r += (cpu_reset === 1'b1);
        end
    endtask

    task pulse_trig(input int k, input logic [15:0] h);
        @(posedge clk);
        stop_enable <= (k == 4);
        fetch_is_opcode <= (k == 2);
        trig[(k < 4) ? k : k - 3] <= 1'b1;
        hold_len <= h;
        ext_go <= 1'b1;
        #1;
        `CHK("reset_on_trigger", k < 4, cpu_reset)
    endtask

    task rd_chk(input logic [7:0] a, input logic [7:0] e);
        wb_xfer(1'b0, a, 32'h0);
        `CHK("read_data", {24'h0, e}, d)
    endtask

    initial begin
        {resetn, low_supply, stop_enable, fetch_is_opcode, trig} = '0;
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_w, ext_go, hold_len} = '0;
        kick_en = 1'b1;
        repeat (9) @(posedge clk);
        #1;
        `CHK("held_in_reset", 5'h18, {cpu_reset, gated, oe_n, bus_clk, pin_o})
        @(posedge clk);
        resetn <= 1'b1;
        wait_vf;
        `CHK("por_fetch", 1'b1, n >= 4160 && n <= 4162)
        `CHK("por_pin_low", 1'b1, lo >= 4128 && lo <= 4130)
        `CHK("por_gated", 1'b1, g >= 4096 && g <= 4098)
        `CHK("vector", 16'hfffe, vec_addr)
        {prev, hi, tr} = '0;
        repeat (8) begin
            @(posedge clk);
            #1;
            hi += (bus_clk === 1'b1);
            tr += (bus_clk !== prev);
            prev = bus_clk;
        end
        `CHK("bus_clk", 8'h44, {hi[3:0], tr[3:0]})
        rd_chk(rst_seq_pkg::ADR_IRQ_STAT, 8'h01);
        `CHK("irq_masked", 1'b0, irq)
        wb_xfer(1'b1, rst_seq_pkg::ADR_IRQ_EN, 32'h1);
        #1;
        `CHK("irq_on", 1'b1, irq)
        wb_xfer(1'b1, rst_seq_pkg::ADR_IRQ_CLR, 32'h7);
        #1;
        `CHK("irq_off", 1'b0, irq)
        rd_chk(rst_seq_pkg::ADR_CAUSE, rst_seq_pkg::CAUSE_POR_RST);
        rd_chk(rst_seq_pkg::ADR_CAUSE, 8'h00);
        wb_xfer(1'b1, rst_seq_pkg::ADR_CAUSE, 32'hff);
        rd_chk(rst_seq_pkg::ADR_CAUSE, 8'h00);
        rd_chk(8'h10, 8'h00);
        @(posedge clk);
        hold_len <= 16'h8;
        ext_go <= 1'b1;
        idle_chk(40);
        `CHK("short_low_ignored", 0, r)
        @(posedge clk);
        hold_len <= 16'h14;
        ext_go <= 1'b1;
        wait_vf;
        rd_chk(rst_seq_pkg::ADR_CAUSE, 8'h40);
        for (int k = 0; k < 6; k++) begin
            pulse_trig(k, 16'h0);
            if (k < 4) begin
                wait_vf;
                `CHK("pin_drive", 32, lo)
                `CHK("hold_end", 65, n)
            end else begin
                idle_chk(4);
                `CHK("no_reset", 0, r)
            end
        end
        rd_chk(rst_seq_pkg::ADR_CAUSE, 8'h1c);
        pulse_trig(0, 16'h46);
        wait_vf;
        idle_chk(80);
        rd_chk(rst_seq_pkg::ADR_CAUSE, 8'h50);
        rd_chk(rst_seq_pkg::ADR_IRQ_STAT, 8'h03);
        @(posedge clk);
        kick_en <= 1'b0;
        wait_vf;
        kick_en <= 1'b1;
        `CHK("wdog_fires", 1'b1, n >= 64 && n <= 140)
        rd_chk(rst_seq_pkg::ADR_CAUSE, 8'h20);
        wb_xfer(1'b1, rst_seq_pkg::ADR_IRQ_CLR, 32'h7);
        @(posedge clk);
        low_supply <= 1'b1;
        repeat (20) @(posedge clk);
        #1;
        `CHK("low_supply_hold", 2'b10, {gated, oe_n})
        @(posedge clk);
        low_supply <= 1'b0;
        wait_vf;
        `CHK("lv_fetch", 1'b1, n >= 4160 && n <= 4164)
        `CHK("lv_pin_low", 1'b1, lo >= 4128 && lo <= 4134)
        rd_chk(rst_seq_pkg::ADR_CAUSE, 8'h02);
        rd_chk(rst_seq_pkg::ADR_IRQ_STAT, 8'h05);
        pulse_trig(3, 16'h0);
        wait_vf;
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        wait_vf;
        rd_chk(rst_seq_pkg::ADR_CAUSE, rst_seq_pkg::CAUSE_POR_RST);
        conclude();
    end
endmodule
